// ===== src/adccal_regs.svh
// Register map, field positions, reset values and response codes of the calibration control block
// How it works
// - In dual-channel mode the swap bit 0 routes input A to channel A and B to B, 1 exchanges them, single mode ignores it.
// - In single-channel mode select value 1 (reset) picks input A, 2 picks input B, 0 and 3 are reserved, dual mode ignores it.
// - Calibration runs while the run bit is high (reset 1) and is held in reset while it is low.
// - A low run bit also holds the digital and serial link clock dividers in reset.
// - The offset filter enable bit turns offset filtering on when set while the run bit is high, and it resets to off.
// - Background offset calibration runs only when its bit and background calibration are both enabled, reset off.
// - Foreground offset calibration runs only when its bit and foreground calibration are both enabled, reset off.
// - The background calibration enable bit turns continuous background calibration on or off, reset off.
// - Each calibration start resets calibration values, then runs foreground calibration if enabled or skips it.
// - The halted status bit reads 1 once background calibration has stopped at the requested phase and 0 on resume.
// - With background calibration disabled the halted bit is set once foreground calibration completes or is skipped.
// - The foreground complete bit, bit 0 of the status register, goes high when foreground calibration finishes.
// - The status pin follows foreground complete for source 0, the alarm for 2, stays low for 3, 1 is reserved.
`ifndef ADCCAL_REGS_SVH
`define ADCCAL_REGS_SVH

// Register indices; the byte address on the bus is four times the index
`define ADCCAL_OFF_INPUT_SEL   8'h60
`define ADCCAL_OFF_RUN_CTRL    8'h61
`define ADCCAL_OFF_CAL_CFG     8'h62
`define ADCCAL_OFF_CAL_STATE   8'h6A
`define ADCCAL_OFF_PIN_CFG     8'h6B
`define ADCCAL_OFF_IRQ_STATUS  8'hA0
`define ADCCAL_OFF_IRQ_MASK    8'hA4
`define ADCCAL_OFF_OFS_ADJ_B_IN_A 8'h92
`define ADCCAL_OFF_OFS_ADJ_B_IN_B 8'h94
`define ADCCAL_OFF_OFS_FILT_ZERO  8'h97
`define ADCCAL_OFF_OFS_FILT_ONE   8'h98

`define ADCCAL_RST_INPUT_SEL   8'h01
`define ADCCAL_RST_RUN_CTRL    8'h01
`define ADCCAL_RST_CAL_CFG     8'h01
`define ADCCAL_RST_PIN_CFG     8'h00
`define ADCCAL_RST_OFS_FILT_ZERO 8'h00
`define ADCCAL_RST_OFS_FILT_ONE  8'h33
// Offset adjustment words power up undefined; zero is an arbitrary choice
`define ADCCAL_RST_OFS_ADJ       16'h0000

`define ADCCAL_BIT_SWAP        4
`define ADCCAL_BIT_OFS_FILT    4
`define ADCCAL_BIT_BG_OFS      3
`define ADCCAL_BIT_FG_OFS      2
`define ADCCAL_BIT_BG          1
`define ADCCAL_BIT_FG          0
`define ADCCAL_BIT_HALTED      1
`define ADCCAL_BIT_FG_CMPL     0

`define ADCCAL_SEL_INPUT_A     2'h1
`define ADCCAL_SEL_INPUT_B     2'h2
`define ADCCAL_PIN_FG_CMPL     2'h0
`define ADCCAL_PIN_ALARM       2'h2

`define ADCCAL_RESP_OKAY       2'h0
`define ADCCAL_RESP_SLVERR     2'h2

`endif

// ===== src/adccal_pkg.sv
// Types shared by the calibration control block
package adccal_pkg;
  typedef enum logic [3:0] {
    ADCCAL_ST_HOLD  = 4'b0001,
    ADCCAL_ST_START = 4'b0010,
    ADCCAL_ST_FG    = 4'b0100,
    ADCCAL_ST_RUN   = 4'b1000
  } adccal_state_t;
  typedef logic [1:0] adccal_isel_t;
endpackage

// ===== src/adccal_ctrl.sv
// Calibration control register bank with AXI4-Lite slave and calibration sequencer
//
// Our own choice: the AXI4-Lite slave port.
`include "adccal_regs.svh"

module adccal_ctrl (
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  input  wire logic [9:0]             s_axi_awaddr,
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  output logic [1:0]                  s_axi_bresp,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  input  wire logic [9:0]             s_axi_araddr,
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  output logic [31:0]                 s_axi_rdata,
  output logic [1:0]                  s_axi_rresp,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  input  wire logic                   single_channel_mode,
  input  wire logic                   fg_cal_finished,
  input  wire logic                   bg_cal_stopped,
  input  wire logic                   alarm_in,
  output logic                        core_a_uses_input_b,
  output logic                        core_b_uses_input_a,
  output logic                        cal_reset,
  output logic                        clk_div_reset,
  output logic                        fg_cal_run,
  output logic                        fg_offset_cal_run,
  output logic                        bg_cal_run,
  output logic                        bg_offset_cal_run,
  output logic                        offset_filter_on,
  output logic                        calibration_status_pin,
  output logic                        irq
);
  import adccal_pkg::*;

  logic [7:0]    input_sel_q;
  logic [7:0]    run_ctrl_q;
  logic [7:0]    cal_cfg_q;
  logic [7:0]    pin_cfg_q;
  logic [1:0]    irq_status_q;
  logic [1:0]    irq_mask_q;
  logic [15:0]   ofs_adj_b_in_a_q;
  logic [15:0]   ofs_adj_b_in_b_q;
  logic [7:0]    ofs_filt_zero_q;
  logic [7:0]    ofs_filt_one_q;
  logic          fg_complete_q;
  logic          halted_q;
  adccal_state_t state_q;

  logic          aw_held_q;
  logic [7:0]    aw_addr_q;
  logic          w_held_q;
  logic [31:0]   w_data_q;
  logic [3:0]    w_strb_q;
  logic          wr_go;
  logic          wr_lane0;
  logic [7:0]    wr_byte;
  logic [31:0]   rd_word;
  logic          rd_hit;
  logic          wr_hit;
  logic          run_bit;
  logic          fg_complete_d;
  logic          halted_d;

  assign run_bit = run_ctrl_q[0];

  // Write channel: address and data captured in either order, response after both
  assign wr_go    = aw_held_q && w_held_q && !s_axi_bvalid;
  assign wr_lane0 = w_strb_q[0];
  assign wr_byte  = w_data_q[7:0];

  always_comb begin
    case (aw_addr_q)
      `ADCCAL_OFF_INPUT_SEL, `ADCCAL_OFF_RUN_CTRL, `ADCCAL_OFF_CAL_CFG, `ADCCAL_OFF_CAL_STATE,
      `ADCCAL_OFF_PIN_CFG, `ADCCAL_OFF_IRQ_STATUS, `ADCCAL_OFF_IRQ_MASK, `ADCCAL_OFF_OFS_ADJ_B_IN_A,
      `ADCCAL_OFF_OFS_ADJ_B_IN_B, `ADCCAL_OFF_OFS_FILT_ZERO, `ADCCAL_OFF_OFS_FILT_ONE: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q     <= 1'b0;
      aw_addr_q     <= 8'h00;
      s_axi_awready <= 1'b0;
    end else if (wr_go) begin
      aw_held_q     <= 1'b0;
      s_axi_awready <= 1'b0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_q     <= 1'b1;
      aw_addr_q     <= s_axi_awaddr[9:2];
      s_axi_awready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_held_q && !s_axi_bvalid;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_q     <= 1'b0;
      w_data_q     <= 32'h0000_0000;
      w_strb_q     <= 4'h0;
      s_axi_wready <= 1'b0;
    end else if (wr_go) begin
      w_held_q     <= 1'b0;
      s_axi_wready <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_q     <= 1'b1;
      w_data_q     <= s_axi_wdata;
      w_strb_q     <= s_axi_wstrb;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_wready <= !w_held_q && !s_axi_bvalid;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `ADCCAL_RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_hit ? `ADCCAL_RESP_OKAY : `ADCCAL_RESP_SLVERR;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Control registers; the status register offset decodes but takes no data
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      input_sel_q <= `ADCCAL_RST_INPUT_SEL;
      run_ctrl_q  <= `ADCCAL_RST_RUN_CTRL;
      cal_cfg_q   <= `ADCCAL_RST_CAL_CFG;
      pin_cfg_q   <= `ADCCAL_RST_PIN_CFG;
      irq_mask_q  <= 2'h0;
      ofs_filt_zero_q <= `ADCCAL_RST_OFS_FILT_ZERO;
      ofs_filt_one_q  <= `ADCCAL_RST_OFS_FILT_ONE;
    end else if (wr_go && wr_lane0) begin
      case (aw_addr_q)
        `ADCCAL_OFF_INPUT_SEL: input_sel_q <= wr_byte;
        `ADCCAL_OFF_RUN_CTRL:  run_ctrl_q  <= wr_byte;
        `ADCCAL_OFF_CAL_CFG:   cal_cfg_q   <= wr_byte;
        `ADCCAL_OFF_PIN_CFG:   pin_cfg_q   <= wr_byte;
        `ADCCAL_OFF_IRQ_MASK:  irq_mask_q  <= wr_byte[1:0];
        `ADCCAL_OFF_OFS_FILT_ZERO: ofs_filt_zero_q <= wr_byte;
        `ADCCAL_OFF_OFS_FILT_ONE:  ofs_filt_one_q  <= wr_byte;
        default: ;
      endcase
    end
  end

  // Offset adjustment words are held for bus readback only; each byte lane has its own strobe
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ofs_adj_b_in_a_q <= `ADCCAL_RST_OFS_ADJ;
    end else if (wr_go && aw_addr_q == `ADCCAL_OFF_OFS_ADJ_B_IN_A) begin
      if (w_strb_q[0]) begin
        ofs_adj_b_in_a_q[7:0] <= w_data_q[7:0];
      end
      if (w_strb_q[1]) begin
        ofs_adj_b_in_a_q[15:8] <= w_data_q[15:8];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ofs_adj_b_in_b_q <= `ADCCAL_RST_OFS_ADJ;
    end else if (wr_go && aw_addr_q == `ADCCAL_OFF_OFS_ADJ_B_IN_B) begin
      if (w_strb_q[0]) begin
        ofs_adj_b_in_b_q[7:0] <= w_data_q[7:0];
      end
      if (w_strb_q[1]) begin
        ofs_adj_b_in_b_q[15:8] <= w_data_q[15:8];
      end
    end
  end

  // Read channel
  always_comb begin
    rd_hit  = 1'b1;
    rd_word = 32'h0000_0000;
    case (s_axi_araddr[9:2])
      `ADCCAL_OFF_INPUT_SEL:  rd_word[7:0] = input_sel_q;
      `ADCCAL_OFF_RUN_CTRL:   rd_word[7:0] = run_ctrl_q;
      `ADCCAL_OFF_CAL_CFG:    rd_word[7:0] = cal_cfg_q;
      `ADCCAL_OFF_CAL_STATE:  rd_word[1:0] = {halted_q, fg_complete_q};
      `ADCCAL_OFF_PIN_CFG:    rd_word[7:0] = pin_cfg_q;
      `ADCCAL_OFF_IRQ_STATUS: rd_word[1:0] = irq_status_q;
      `ADCCAL_OFF_IRQ_MASK:   rd_word[1:0] = irq_mask_q;
      `ADCCAL_OFF_OFS_ADJ_B_IN_A: rd_word[15:0] = ofs_adj_b_in_a_q;
      `ADCCAL_OFF_OFS_ADJ_B_IN_B: rd_word[15:0] = ofs_adj_b_in_b_q;
      `ADCCAL_OFF_OFS_FILT_ZERO:  rd_word[7:0]  = ofs_filt_zero_q;
      `ADCCAL_OFF_OFS_FILT_ONE:   rd_word[7:0]  = ofs_filt_one_q;
      default:                rd_hit       = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `ADCCAL_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_word;
      s_axi_rresp   <= rd_hit ? `ADCCAL_RESP_OKAY : `ADCCAL_RESP_SLVERR;
    end else if (s_axi_rvalid) begin
      if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end else begin
      s_axi_arready <= 1'b1;
    end
  end

  // Calibration sequencer: reset values, then optional foreground pass, then run
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= ADCCAL_ST_HOLD;
    end else if (!run_bit) begin
      state_q <= ADCCAL_ST_HOLD;
    end else begin
      case (state_q)
        ADCCAL_ST_HOLD:  state_q <= ADCCAL_ST_START;
        ADCCAL_ST_START: state_q <= cal_cfg_q[`ADCCAL_BIT_FG] ? ADCCAL_ST_FG : ADCCAL_ST_RUN;
        ADCCAL_ST_FG:    state_q <= fg_cal_finished ? ADCCAL_ST_RUN : ADCCAL_ST_FG;
        ADCCAL_ST_RUN:   state_q <= ADCCAL_ST_RUN;
        default:         state_q <= ADCCAL_ST_HOLD;
      endcase
    end
  end

  // Status bits
  always_comb begin
    fg_complete_d = fg_complete_q;
    halted_d      = halted_q;
    // Start clears first, so a skipped foreground pass still sets halted in that cycle
    if (state_q == ADCCAL_ST_START) begin
      fg_complete_d = 1'b0;
      halted_d      = 1'b0;
    end
    if (state_q == ADCCAL_ST_FG && fg_cal_finished) begin
      fg_complete_d = 1'b1;
    end
    if (cal_cfg_q[`ADCCAL_BIT_BG]) begin
      if (state_q == ADCCAL_ST_RUN) begin
        halted_d = bg_cal_stopped;
      end
    end else if ((state_q == ADCCAL_ST_FG && fg_cal_finished) ||
                 (state_q == ADCCAL_ST_START && !cal_cfg_q[`ADCCAL_BIT_FG])) begin
      halted_d = 1'b1;
    end
    if (!run_bit) begin
      fg_complete_d = 1'b0;
      halted_d      = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fg_complete_q <= 1'b0;
      halted_q      <= 1'b0;
    end else begin
      fg_complete_q <= fg_complete_d;
      halted_q      <= halted_d;
    end
  end

  // Sticky events on rising status bits; set wins over a write-one clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_status_q <= 2'h0;
    end else begin
      irq_status_q <= (irq_status_q & ~((wr_go && wr_lane0 && aw_addr_q == `ADCCAL_OFF_IRQ_STATUS) ?
                       wr_byte[1:0] : 2'h0)) | ({halted_d, fg_complete_d} & ~{halted_q, fg_complete_q});
    end
  end

  // Outputs, all registered
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      core_a_uses_input_b    <= 1'b0;
      core_b_uses_input_a    <= 1'b0;
      cal_reset              <= 1'b1;
      clk_div_reset          <= 1'b1;
      fg_cal_run             <= 1'b0;
      fg_offset_cal_run      <= 1'b0;
      bg_cal_run             <= 1'b0;
      bg_offset_cal_run      <= 1'b0;
      offset_filter_on       <= 1'b0;
      calibration_status_pin <= 1'b0;
      irq                    <= 1'b0;
    end else begin
      if (single_channel_mode) begin
        core_a_uses_input_b <= input_sel_q[1:0] == `ADCCAL_SEL_INPUT_B;
        core_b_uses_input_a <= input_sel_q[1:0] == `ADCCAL_SEL_INPUT_A;
      end else begin
        core_a_uses_input_b <= input_sel_q[`ADCCAL_BIT_SWAP];
        core_b_uses_input_a <= input_sel_q[`ADCCAL_BIT_SWAP];
      end
      cal_reset         <= !run_bit;
      clk_div_reset     <= !run_bit;
      fg_cal_run        <= state_q == ADCCAL_ST_FG;
      fg_offset_cal_run <= state_q == ADCCAL_ST_FG && cal_cfg_q[`ADCCAL_BIT_FG_OFS];
      bg_cal_run        <= state_q == ADCCAL_ST_RUN && cal_cfg_q[`ADCCAL_BIT_BG];
      bg_offset_cal_run <= state_q == ADCCAL_ST_RUN && cal_cfg_q[`ADCCAL_BIT_BG] &&
                           cal_cfg_q[`ADCCAL_BIT_BG_OFS];
      offset_filter_on  <= run_bit && cal_cfg_q[`ADCCAL_BIT_OFS_FILT];
      case (pin_cfg_q[2:1])
        `ADCCAL_PIN_FG_CMPL: calibration_status_pin <= fg_complete_q;
        `ADCCAL_PIN_ALARM:  calibration_status_pin <= alarm_in;
        default:            calibration_status_pin <= 1'b0;
      endcase
      irq <= |(irq_status_q & irq_mask_q);
    end
  end

endmodule // adccal_ctrl

// ===== dv/adccal_assertions.sv
// Port-level assertions of the calibration control block
module adccal_chk (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic single_channel_mode,
  input wire logic core_a_uses_input_b,
  input wire logic core_b_uses_input_a,
  input wire logic cal_reset,
  input wire logic clk_div_reset,
  input wire logic fg_cal_run,
  input wire logic fg_offset_cal_run,
  input wire logic bg_cal_run,
  input wire logic bg_offset_cal_run,
  input wire logic offset_filter_on
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  AST_WR_ANSWER: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:2] s_axi_bvalid) else $error("write response missing");
  AST_RD_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response missing");
  AST_DIV_RESET: assert property (cal_reset == clk_div_reset) else $error("divider reset differs");
  AST_HOLD: assert property (cal_reset && $past(cal_reset) |-> !fg_cal_run && !bg_cal_run && !offset_filter_on)
    else $error("calibration active while held");
  AST_FG_OFFSET: assert property (fg_offset_cal_run |-> fg_cal_run) else $error("fg offset without fg");
  AST_BG_OFFSET: assert property (bg_offset_cal_run |-> bg_cal_run) else $error("bg offset without bg");
  AST_PHASES: assert property (!(fg_cal_run && bg_cal_run)) else $error("fg and bg together");
  AST_DUAL_SWAP: assert property (!single_channel_mode && $past(!single_channel_mode)
    |-> core_a_uses_input_b == core_b_uses_input_a) else $error("dual routing not symmetric");
  AST_SINGLE_SEL: assert property (single_channel_mode && $past(single_channel_mode)
    |-> !(core_a_uses_input_b && core_b_uses_input_a)) else $error("single routing picks both");
  AST_FILTER_RUN: assert property (offset_filter_on |-> !cal_reset) else $error("filter on while held");
endmodule // adccal_chk

bind adccal_ctrl adccal_chk u_chk (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .single_channel_mode(single_channel_mode),
  .core_a_uses_input_b(core_a_uses_input_b), .core_b_uses_input_a(core_b_uses_input_a),
  .cal_reset(cal_reset), .clk_div_reset(clk_div_reset), .fg_cal_run(fg_cal_run),
  .fg_offset_cal_run(fg_offset_cal_run), .bg_cal_run(bg_cal_run), .bg_offset_cal_run(bg_offset_cal_run),
  .offset_filter_on(offset_filter_on));

// ===== dv/tb.sv
// Testbench of the calibration control register bank
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic        single_channel_mode, fg_cal_finished, bg_cal_stopped, alarm_in, irq;
  logic        core_a_uses_input_b, core_b_uses_input_a, cal_reset, clk_div_reset, fg_cal_run;
  logic        fg_offset_cal_run, bg_cal_run, bg_offset_cal_run, offset_filter_on, calibration_status_pin;
  logic [9:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rv;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
  int          bad_count, num_checks, cyc;

  adccal_ctrl dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .single_channel_mode, .fg_cal_finished, .bg_cal_stopped, .alarm_in,
    .core_a_uses_input_b, .core_b_uses_input_a, .cal_reset, .clk_div_reset, .fg_cal_run,
    .fg_offset_cal_run, .bg_cal_run, .bg_offset_cal_run, .offset_filter_on, .calibration_status_pin, .irq);

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wrw(input logic [7:0] a, input logic [15:0] d);
    @(posedge aclk);
    s_axi_awaddr <= {a, 2'b00};
    s_axi_wdata <= {16'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    wrw(a, {8'h00, d});
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= {a, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    rv = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    rd(a);
    chk(rv, {24'h0, e});
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge aclk);
  endtask

  always @(posedge aclk) begin
    cyc++;
    if (cyc > 5000) begin
      bad_count++;
      test_done();
    end
  end

  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
    {single_channel_mode, fg_cal_finished, bg_cal_stopped, alarm_in} = 4'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 52'h0;
    s_axi_wstrb = 4'hF;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    idle(2);
    rchk(8'h60, 8'h01);
    rchk(8'h61, 8'h01);
    rchk(8'h62, 8'h01);
    rchk(8'h6B, 8'h00);
    rchk(8'h97, 8'h00);
    rchk(8'h98, 8'h33);
    rd(8'h92);
    chk(rv, 32'h0000_0000);
    wrw(8'h92, 16'hA55A);
    wrw(8'h94, 16'h1234);
    wr(8'h98, 8'hC3);
    rd(8'h92);
    chk(rv, 32'h0000_A55A);
    rd(8'h94);
    chk(rv, 32'h0000_1234);
    rchk(8'h98, 8'hC3);
    rd(8'h70);
    chk(32'(resp), 32'h2);
    chk(32'({core_a_uses_input_b, core_b_uses_input_a}), 32'h0);
    wr(8'h60, 8'h10);
    idle(2);
    chk(32'({core_a_uses_input_b, core_b_uses_input_a}), 32'h3);
    single_channel_mode <= 1'b1;
    wr(8'h60, 8'h11);
    idle(2);
    chk(32'({core_a_uses_input_b, core_b_uses_input_a}), 32'h1);
    wr(8'h60, 8'h12);
    idle(2);
    chk(32'({core_a_uses_input_b, core_b_uses_input_a}), 32'h2);
    single_channel_mode <= 1'b0;
    wr(8'h61, 8'h00);
    idle(2);
    chk(32'({cal_reset, clk_div_reset}), 32'h3);
    rchk(8'h6A, 8'h00);
    wr(8'h62, 8'h1F);
    rchk(8'h62, 8'h1F);
    wr(8'hA4, 8'h03);
    wr(8'h61, 8'h01);
    idle(3);
    chk(32'({fg_cal_run, fg_offset_cal_run, offset_filter_on, bg_cal_run}), 32'hE);
    chk(32'(irq), 32'h0);
    fg_cal_finished <= 1'b1;
    idle(3);
    fg_cal_finished <= 1'b0;
    chk(32'({fg_cal_run, bg_cal_run, bg_offset_cal_run}), 32'h3);
    rchk(8'h6A, 8'h01);
    chk(32'({calibration_status_pin, irq}), 32'h3);
    bg_cal_stopped <= 1'b1;
    idle(3);
    rchk(8'h6A, 8'h03);
    rchk(8'hA0, 8'h03);
    rchk(8'hA4, 8'h03);
    bg_cal_stopped <= 1'b0;
    idle(3);
    rchk(8'h6A, 8'h01);
    wr(8'h6A, 8'h00);
    rchk(8'h6A, 8'h01);
    wr(8'h6B, 8'h04);
    idle(2);
    chk(32'(calibration_status_pin), 32'h0);
    alarm_in <= 1'b1;
    idle(2);
    chk(32'(calibration_status_pin), 32'h1);
    wr(8'h6B, 8'h06);
    idle(2);
    chk(32'(calibration_status_pin), 32'h0);
    wr(8'hA0, 8'h03);
    idle(2);
    chk(32'(irq), 32'h0);
    rchk(8'hA0, 8'h00);
    wr(8'h61, 8'h00);
    wr(8'h62, 8'h00);
    wr(8'h61, 8'h01);
    idle(4);
    rchk(8'h6A, 8'h02);
    chk(32'({fg_cal_run, bg_cal_run, offset_filter_on, irq}), 32'h1);
    wr(8'h70, 8'h55);
    chk(32'(resp), 32'h2);
    test_done();
  end
endmodule // tb
